/* shared/cfr_map.vh */
// Purpose: Constants for the cache and feature configuration registers
// Assumes: Included by the register bank and its bench
// Notes: Field positions, reset values and access codes
// Functional notes
// RULE1: bit 31 flags next configuration register
// RULE2: third level high half, second level low
// RULE3: impl control fields writable or read zero
// RULE4: sets codes 0-7 are 64..8192, rest reserved
// RULE5: line size zero means level absent
// RULE6: ways zero is direct mapped, 1-7 more
// RULE7: feature register read-only except entry selector
// RULE8: bit 30 reads zero, software writes zero
// RULE9: single-bit feature presence flags
// RULE10: revision 6 forces fault instruction flags
// RULE11: priority width code 0 six, 1 eight
// RULE12: eight-bit priority uses extra status bits
// RULE13: compact revision field encoding
// RULE14: availability zero means no compact set
// RULE15: exception entry selector rules
// RULE16: availability field encoding
// RULE17: thread local flag per revision and mode
// RULE18: read-only fields keep values, preset at reset
`ifndef CFR_MAP_VH
`define CFR_MAP_VH

// ==========================================================
// Register selects
`define CFR_SEL_CACHE 1'b0
`define CFR_SEL_FEAT 1'b1

// ==========================================================
// Cache hierarchy field positions
`define CFR_NEXT_BIT 31
`define CFR_L3_CTRL_HI 30
`define CFR_L3_CTRL_LO 28
`define CFR_L3_SETS_LO 24
`define CFR_L3_LINE_LO 20
`define CFR_L3_WAYS_LO 16
`define CFR_L2_CTRL_HI 15
`define CFR_L2_CTRL_LO 12
`define CFR_L2_SETS_LO 8
`define CFR_L2_LINE_LO 4
`define CFR_L2_WAYS_LO 0

// ==========================================================
// Feature presence field positions
`define CFR_ZERO_BIT 30
`define CFR_COH_BIT 29
`define CFR_SIMD_BIT 28
`define CFR_PRIOR_BIT 27
`define CFR_FAULT_BIT 26
`define CFR_SEG_BIT 25
`define CFR_WALK_BIT 24
`define CFR_VIRT_BIT 23
`define CFR_PRIW_LO 21
`define CFR_CREV_LO 18
`define CFR_MCU_BIT 17
`define CFR_EXC_BIT 16
`define CFR_ISA_LO 14
`define CFR_TLS_BIT 13

// ==========================================================
// Encodings and reset values
`define CFR_ISA_BASE 2'h0
`define CFR_ISA_COMPACT 2'h1
`define CFR_ISA_BOTH_BASE 2'h2
`define CFR_ISA_BOTH_COMPACT 2'h3
`define CFR_REV6 2'h2
`define CFR_FIELD_MAX 4'h7
`define CFR_CTRL3_RST 3'h0
`define CFR_CTRL4_RST 4'h0
`define CFR_EXC_RST 1'b0

`endif

/* logic/cfr_presets.v */
// Purpose: Holds the preset capability words of both registers
// Assumes: Presets are static straps of the implementation
// Notes: Read data leave a register, as a tiny two-word store
`timescale 1ns/1ps
`include "cfr_map.vh"

module cfr_presets #(
	parameter [31:0] CACHE_WORD = 32'h0000_0000,
	parameter [31:0] FEAT_WORD = 32'h0000_0000
) (
	input wire mclk,
	input wire nrst,
	input wire sel,
	output reg [31:0] rdata_q
);

	// ==========================================================
	// Registered read of the preset word
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 32'h0000_0000;
		end else if (sel == `CFR_SEL_FEAT) begin
			rdata_q <= FEAT_WORD; // RULE18
		end else begin
			rdata_q <= CACHE_WORD; // RULE18
		end
	end

endmodule

/* logic/cfr_regs.v */
// Purpose: Cache hierarchy and feature presence configuration registers
// Assumes: Coprocessor move port, same clock as the core
// Notes: Reads answer two cycles after the read strobe
`timescale 1ns/1ps
`include "cfr_map.vh"

module cfr_regs #(
	parameter [0:0] NEXT_AFTER_CACHE = 1'b1,
	parameter [0:0] NEXT_AFTER_FEAT = 1'b0,
	parameter [0:0] L3_CTRL_IMPL = 1'b0,
	parameter [0:0] L2_CTRL_IMPL = 1'b0,
	parameter [3:0] L3_SETS = 4'h0,
	parameter [3:0] L3_LINE = 4'h0,
	parameter [3:0] L3_WAYS = 4'h0,
	parameter [3:0] L2_SETS = 4'h2,
	parameter [3:0] L2_LINE = 4'h5,
	parameter [3:0] L2_WAYS = 4'h3,
	parameter [0:0] COH_PRESENT = 1'b0,
	parameter [0:0] SIMD_PRESENT = 1'b0,
	parameter [0:0] PRIOR_PRESENT = 1'b0,
	parameter [0:0] FAULT_PRESENT = 1'b0,
	parameter [0:0] SEG_PRESENT = 1'b0,
	parameter [0:0] WALK_PRESENT = 1'b0,
	parameter [0:0] VIRT_PRESENT = 1'b0,
	parameter [1:0] PRIO_WIDTH = 2'h0,
	parameter [2:0] COMPACT_REV = 3'h0,
	parameter [0:0] MCU_PRESENT = 1'b0,
	parameter [1:0] ISA_AVAIL = 2'h2,
	parameter [1:0] ARCH_REV = 2'h2,
	parameter [0:0] TLS_PRESENT = 1'b1,
	parameter [0:0] SUBSET_MODE = 1'b0
) (
	input wire mclk,
	input wire nrst,
	input wire sel,
	input wire rd_en,
	input wire wr_en,
	input wire [31:0] wdata,
	output reg [31:0] rdata_q,
	output reg rvalid_q,
	output reg exc_isa_q,
	output reg [1:0] priority_width_sel_q,
	output reg [3:0] l2_impl_ctrl_q,
	output reg [2:0] l3_impl_ctrl_q
);

	// ==========================================================
	// Field limiting: reserved codes clamp to the top legal code
	function [3:0] cfr_legal;
		input [3:0] code;
		begin
			if (code > `CFR_FIELD_MAX) begin
				cfr_legal = `CFR_FIELD_MAX;
			end else begin
				cfr_legal = code;
			end
		end
	endfunction

	// ==========================================================
	// Derived presets
	localparam [0:0] REV6 = (ARCH_REV == `CFR_REV6);
	localparam [0:0] PRIOR_EFF = REV6 ? 1'b1 : PRIOR_PRESENT;
	localparam [0:0] FAULT_EFF = REV6 ? 1'b1 : FAULT_PRESENT;
	localparam [0:0] TLS_EFF = REV6 ? ~SUBSET_MODE : TLS_PRESENT;
	localparam [0:0] HAS_COMPACT = (ISA_AVAIL != `CFR_ISA_BASE);
	localparam [2:0] CREV_EFF = HAS_COMPACT ? COMPACT_REV : 3'h0;
	localparam [1:0] PRIO_EFF = PRIO_WIDTH[1] ? 2'h0 : PRIO_WIDTH;
	localparam [0:0] BOTH_SETS = ISA_AVAIL[1];
	localparam [0:0] ONLY_COMPACT = (ISA_AVAIL == `CFR_ISA_COMPACT);

	// Cache word without writable control fields
	localparam [31:0] CACHE_WORD = {NEXT_AFTER_CACHE, 3'h0,
		L3_SETS, L3_LINE, L3_WAYS, 4'h0, L2_SETS, L2_LINE,
		L2_WAYS};

	// Feature word without the entry selector, low bits zero
	localparam [31:0] FEAT_WORD = {NEXT_AFTER_FEAT, 1'b0,
		COH_PRESENT, SIMD_PRESENT, PRIOR_EFF, FAULT_EFF,
		SEG_PRESENT, WALK_PRESENT, VIRT_PRESENT, PRIO_EFF,
		CREV_EFF, MCU_PRESENT, 1'b0, ISA_AVAIL, TLS_EFF,
		13'h0000};

	// Cache word with illegal codes clamped
	localparam [31:0] CACHE_SAFE = {CACHE_WORD[31:28],
		cfr_legal(L3_SETS), cfr_legal(L3_LINE),
		cfr_legal(L3_WAYS), 4'h0, cfr_legal(L2_SETS),
		cfr_legal(L2_LINE), cfr_legal(L2_WAYS)};

	wire [31:0] preset_rd;
	reg rd_pend_q;
	reg sel_pend_q;
	reg [2:0] l3_ctrl_d;
	reg [3:0] l2_ctrl_d;
	reg exc_d;

	// ==========================================================
	// Preset store
	cfr_presets #(
		.CACHE_WORD(CACHE_SAFE),
		.FEAT_WORD(FEAT_WORD)
	) u_presets (
		.mclk(mclk),
		.nrst(nrst),
		.sel(sel),
		.rdata_q(preset_rd)
	);

	// ==========================================================
	// Write decode: only control fields and the entry selector
	always @* begin
		l3_ctrl_d = l3_impl_ctrl_q;
		l2_ctrl_d = l2_impl_ctrl_q;
		exc_d = exc_isa_q;
		if (wr_en && sel == `CFR_SEL_CACHE) begin
			if (L3_CTRL_IMPL) begin
				l3_ctrl_d = wdata[`CFR_L3_CTRL_HI:`CFR_L3_CTRL_LO]; // RULE3
			end
			if (L2_CTRL_IMPL) begin
				l2_ctrl_d = wdata[`CFR_L2_CTRL_HI:`CFR_L2_CTRL_LO]; // RULE3
			end
		end
		if (wr_en && sel == `CFR_SEL_FEAT && BOTH_SETS) begin
			exc_d = wdata[`CFR_EXC_BIT]; // RULE7
		end
		if (ONLY_COMPACT) begin
			exc_d = 1'b1; // RULE15
		end else if (!HAS_COMPACT) begin
			exc_d = 1'b0; // RULE15
		end
	end

	// ==========================================================
	// Writable state and the fixed priority width select
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			l3_impl_ctrl_q <= `CFR_CTRL3_RST;
			l2_impl_ctrl_q <= `CFR_CTRL4_RST;
			exc_isa_q <= `CFR_EXC_RST;
			priority_width_sel_q <= 2'h0;
		end else begin
			l3_impl_ctrl_q <= l3_ctrl_d; // RULE3
			l2_impl_ctrl_q <= l2_ctrl_d; // RULE3
			exc_isa_q <= exc_d; // RULE15
			priority_width_sel_q <= PRIO_EFF; // RULE11
		end
	end

	// ==========================================================
	// Read pipeline: preset word lands one cycle after the strobe
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_pend_q <= 1'b0;
			sel_pend_q <= 1'b0;
		end else begin
			rd_pend_q <= rd_en;
			sel_pend_q <= sel;
		end
	end

	// ==========================================================
	// Output word: merge live fields into the preset word
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= rd_pend_q;
			if (rd_pend_q && sel_pend_q == `CFR_SEL_CACHE) begin
				// RULE1 RULE2 RULE4 RULE5 RULE6
				rdata_q <= {preset_rd[31], l3_impl_ctrl_q,
					preset_rd[27:16], l2_impl_ctrl_q,
					preset_rd[11:0]};
			end else if (rd_pend_q) begin
				// RULE8 RULE9 RULE10 RULE13 RULE14 RULE16 RULE17
				rdata_q <= {preset_rd[31:17], exc_isa_q,
					preset_rd[15:0]};
			end
		end
	end

	// RULE12 RULE18: priority width steers status bit use outside

endmodule

/* bench/cfr_regs_assertions.sv */
// Purpose: Port-level checks of the configuration register bank
// Assumes: Revision 6 presets, both instruction sets present
// Notes: Bound onto cfr_regs from the bench top file
`timescale 1ns/1ps

module cfr_regs_assertions #(
	parameter [0:0] NEXT_AFTER_CACHE = 1'b1,
	parameter [0:0] L3_CTRL_IMPL = 1'b0,
	parameter [1:0] ISA_AVAIL = 2'h2
) (
	input wire mclk,
	input wire nrst,
	input wire sel,
	input wire rd_en,
	input wire wr_en,
	input wire [31:0] wdata,
	input wire [31:0] rdata_q,
	input wire rvalid_q,
	input wire exc_isa_q,
	input wire [1:0] priority_width_sel_q,
	input wire [3:0] l2_impl_ctrl_q,
	input wire [2:0] l3_impl_ctrl_q
);
	// ==========================================================
	// Read answer timing and word contents
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_read_latency: assert property (rd_en |-> ##2 rvalid_q)
		else $error("read answer late");
	a_no_spurious: assert property (rvalid_q |-> $past(rd_en, 2))
		else $error("answer without read");
	a_next_flag: assert property (rvalid_q && !$past(sel, 2) |->
		rdata_q[31] == NEXT_AFTER_CACHE) else $error("next flag");
	a_zero_bit: assert property (rvalid_q && $past(sel, 2) |->
		!rdata_q[30]) else $error("bit 30 set");
	a_rev6_flags: assert property (rvalid_q && $past(sel, 2) |->
		rdata_q[27:26] == 2'b11) else $error("fault flags");
	a_l3_ctrl_zero: assert property (rvalid_q && !$past(sel, 2) &&
		!L3_CTRL_IMPL |-> rdata_q[30:28] == 3'h0)
		else $error("l3 control not zero");
	a_ctrl_echo: assert property (rvalid_q && !$past(sel, 2) |->
		rdata_q[15:12] == $past(l2_impl_ctrl_q))
		else $error("l2 control readback");
	a_exc_echo: assert property (rvalid_q && $past(sel, 2) |->
		rdata_q[16] == $past(exc_isa_q)) else $error("selector");
	a_exc_write: assert property (wr_en && sel && ISA_AVAIL[1] |=>
		exc_isa_q == $past(wdata[16])) else $error("selector write");
	a_prio_fixed: assert property ($past(nrst) && $past(nrst, 2) |->
		$stable(priority_width_sel_q)) else $error("width moved");
	// Main scenarios reached
	c_cache_read: cover property (rvalid_q && !$past(sel, 2));
	c_feat_read: cover property (rvalid_q && $past(sel, 2));
	c_exc_set: cover property ($rose(exc_isa_q));
endmodule

/* bench/test_cfr_regs.sv */
// Purpose: Self-checking bench of the configuration register bank
// Assumes: Reads answer two edges after the strobe
// Notes: Inputs change on the falling edge of mclk
`timescale 1ns/1ps
`include "cfr_map.vh"
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin \
	failures = failures + 1; $display("[ERR] %0t value mismatch", $time); end end

module test_cfr_regs;
	reg mclk, nrst, sel, rd_en, wr_en;
	reg [31:0] wdata;
	wire [31:0] rdata_q;
	wire rvalid_q, exc_isa_q;
	wire [1:0] priority_width_sel_q;
	wire [3:0] l2_impl_ctrl_q;
	wire [2:0] l3_impl_ctrl_q;
	integer failures = 0, compares = 0;
	// ==========================================================
	// Device under test with a non-trivial preset mix
	cfr_regs #(.L3_LINE(4'h3), .L2_CTRL_IMPL(1'b1), .COH_PRESENT(1'b1),
		.PRIO_WIDTH(2'h1), .MCU_PRESENT(1'b1))
	cfr_regs_i (.mclk(mclk), .nrst(nrst), .sel(sel), .rd_en(rd_en),
		.wr_en(wr_en), .wdata(wdata), .rdata_q(rdata_q),
		.rvalid_q(rvalid_q), .exc_isa_q(exc_isa_q),
		.priority_width_sel_q(priority_width_sel_q),
		.l2_impl_ctrl_q(l2_impl_ctrl_q), .l3_impl_ctrl_q(l3_impl_ctrl_q));
	always #12.5 mclk = ~mclk;
	// Read one word and compare it while the answer stands
	task rd(input s, input [31:0] e);
		begin
			@(negedge mclk) sel = s;
			rd_en = 1'b1;
			@(negedge mclk) rd_en = 1'b0;
			@(posedge mclk);
			#1 `CHK(rvalid_q, 1'b1)
			`CHK(rdata_q, e)
		end
	endtask
	task wr(input s, input [31:0] d);
		begin
			@(negedge mclk) sel = s;
			wr_en = 1'b1;
			wdata = d;
			@(negedge mclk) wr_en = 1'b0;
		end
	endtask
	task wrap_up;
		begin
			$display("compares=%0d failures=%0d", compares, failures);
			if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	// Watchdog against a hung run
	initial begin
		#20000 failures = failures + 1;
		wrap_up;
	end
	// ==========================================================
	// Test sequence
	initial begin
		mclk = 0; nrst = 0; sel = 0; rd_en = 0; wr_en = 0; wdata = 0;
		repeat (3) @(negedge mclk);
		`CHK(priority_width_sel_q, 2'h0)
		nrst = 1'b1;
		@(posedge mclk) #1 `CHK(priority_width_sel_q, 2'h1)
		rd(`CFR_SEL_CACHE, 32'h8030_0253);
		rd(`CFR_SEL_FEAT, 32'h2C22_A000);
		$display("test presets done");
		wr(`CFR_SEL_CACHE, 32'hFFFF_FFFF);
		rd(`CFR_SEL_CACHE, 32'h8030_F253);
		`CHK(l2_impl_ctrl_q, 4'hF)
		`CHK(l3_impl_ctrl_q, 3'h0)
		wr(`CFR_SEL_FEAT, 32'hBFFF_FFFF);
		rd(`CFR_SEL_FEAT, 32'h2C23_A000);
		`CHK(exc_isa_q, 1'b1)
		wr(`CFR_SEL_FEAT, 32'h0000_0000);
		rd(`CFR_SEL_FEAT, 32'h2C22_A000);
		$display("test writes done");
		// Back-to-back reads of both registers
		@(negedge mclk) sel = 1'b0;
		rd_en = 1'b1;
		@(negedge mclk) sel = 1'b1;
		@(posedge mclk) #1 `CHK(rdata_q, 32'h8030_F253)
		@(negedge mclk) rd_en = 1'b0;
		@(posedge mclk) #1 `CHK(rdata_q, 32'h2C22_A000)
		$display("test back to back done");
		// Reset in mid-run restores the presets
		@(negedge mclk) nrst = 1'b0;
		#1 `CHK(l2_impl_ctrl_q, 4'h0)
		@(negedge mclk) nrst = 1'b1;
		rd(`CFR_SEL_CACHE, 32'h8030_0253);
		$display("test reset done");
		wrap_up;
	end
endmodule

bind cfr_regs cfr_regs_assertions #(.NEXT_AFTER_CACHE(NEXT_AFTER_CACHE),
	.L3_CTRL_IMPL(L3_CTRL_IMPL), .ISA_AVAIL(ISA_AVAIL))
chk_i (.mclk(mclk), .nrst(nrst), .sel(sel), .rd_en(rd_en),
	.wr_en(wr_en), .wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
	.exc_isa_q(exc_isa_q), .priority_width_sel_q(priority_width_sel_q),
	.l2_impl_ctrl_q(l2_impl_ctrl_q), .l3_impl_ctrl_q(l3_impl_ctrl_q));
